// ==== hw/bit_sync.sv ====
// Two-flop level synchroniser, one chain per bit.
// Assumes inputs are quasi-static levels or slow toggles.
`timescale 1ns/10ps
`default_nettype none

module bit_sync import qdac_pkg::*; #(
  parameter int WIDTH = SYNC_BITS
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // ----------------------------------------------------------------
  // Synchroniser chains
  // ----------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_chain
      logic meta;       // First stage, read only by the second
      logic next_meta;  // Next first stage
      logic next_sync;  // Next second stage

      // Next values; frozen while the clock enable is low
      always_comb begin
        next_meta = i_ce ? i_async[b] : meta;
        next_sync = i_ce ? meta : o_sync[b];
      end

      // Registers only
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          meta <= 1'b0;
          o_sync[b] <= 1'b0;
        end else begin
          meta <= next_meta;
          o_sync[b] <= next_sync;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ==== hw/qdac_pkg.sv ====
// Shared constants and types for the quad converter serial load logic.
// Assumes every design file imports the whole package, in its module header or, for the interface, its body.
package qdac_pkg;

  // ----------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 24;     // Bits per serial transfer
  localparam int CODE_BITS = 16;     // Converter code width
  localparam int CHANNELS = 4;       // Number of converter channels
  localparam int ADDR_HI_POS = 23;   // First bit received, channel_addr_hi
  localparam int ADDR_LO_POS = 22;   // Second bit received, channel_addr_lo
  localparam int BCAST_POS = 21;     // Third bit received, broadcast flag
  localparam int CODE_MSB_POS = 15;  // Code occupies the last sixteen bits

  // ----------------------------------------------------------------
  // Reset codes
  // ----------------------------------------------------------------
  localparam logic [15:0] MIDSCALE_CODE = 16'h8000;  // Reset with select high
  localparam logic [15:0] ZERO_CODE = 16'h0000;      // Reset with select low

  // ----------------------------------------------------------------
  // Crossing and synchroniser layout
  // ----------------------------------------------------------------
  localparam logic [1:0] QUIET_CYCLES = 2'h3;  // Quiet cycles before word capture
  localparam int SYNC_BITS = 5;                // Inputs passing the synchroniser
  localparam int SYNC_TOGGLE = 0;              // Shift toggle from link domain
  localparam int SYNC_LOAD = 1;                // Active-low load strobe pin
  localparam int SYNC_UPDATE = 2;              // Output update strobe pin
  localparam int SYNC_RESET = 3;               // Code reset pin
  localparam int SYNC_SELECT = 4;              // Reset level select pin

  typedef logic [WORD_BITS-1:0] word_t;  // One serial word
  typedef logic [CODE_BITS-1:0] code_t;  // One converter code

endpackage

// ==== hw/quad_dac_serial_load_logic.sv ====
// Digital load logic of a four-channel 16-bit converter.
// Assumes a host drives serial clock, select, data and the strobes.
//
// How it works
// - Word: address, broadcast, five spare, code
// - First two bits address the register
// - Broadcast bit high loads all four
// - Broadcast low loads addressed channel only
// - Input and output register per channel
// - Chip select gates shifting
// - Code reset edge acts without serial clock
// - Reset sets all registers at once
// - Select high gives mid-scale, low zero
// - Shift on rising edge; host times select
// - Input registers follow shifter while load low
// - Update edge copies all inputs to outputs
`timescale 1ns/10ps
`default_nettype none

module quad_dac_serial_load_logic import qdac_pkg::*; (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_serial_in,
  input wire logic i_load_n,
  input wire logic i_output_update_strobe,
  input wire logic i_code_reset,
  input wire logic i_reset_level_select,
  output logic o_serial_out,
  output logic [CHANNELS-1:0][CODE_BITS-1:0] o_input_code,
  output logic [CHANNELS-1:0][CODE_BITS-1:0] o_code
);

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  serial_word_if link ();  // Shift word and its event toggle

  // Shifter on the serial clock
  serial_shifter u_shifter (
    .i_sclk(i_sclk),
    .i_arst_n(i_arst_n),
    .i_cs_n(i_cs_n),
    .i_serial_in(i_serial_in),
    .link(link)
  );

  // chain output from the top stage flop
  assign o_serial_out = link.word[WORD_BITS-1];

  // ----------------------------------------------------------------
  // Pin and toggle synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_BITS-1:0] raw_async;  // Asynchronous levels
  logic [SYNC_BITS-1:0] synced;     // Same, two flops later

  // Gather the inputs in the order of the index constants
  always_comb begin
    raw_async = '0;
    raw_async[SYNC_TOGGLE] = link.toggle;
    raw_async[SYNC_LOAD] = i_load_n;
    raw_async[SYNC_UPDATE] = i_output_update_strobe;
    raw_async[SYNC_RESET] = i_code_reset;
    raw_async[SYNC_SELECT] = i_reset_level_select;
  end

  bit_sync #(
    .WIDTH(SYNC_BITS)
  ) u_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_async(raw_async),
    .o_sync(synced)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // True when a word steers its code into channel idx
  function automatic logic chan_hit(input word_t w, input logic [1:0] idx);
    logic [1:0] addr;
    addr = {w[ADDR_HI_POS], w[ADDR_LO_POS]};
    chan_hit = w[BCAST_POS] || (addr == idx);
  endfunction

  // ----------------------------------------------------------------
  // Word capture across the clock boundary
  // ----------------------------------------------------------------
  logic toggle_seen;        // Last synchronised toggle value
  logic next_toggle_seen;   // Next value of the same
  logic [1:0] quiet_cnt;    // Cycles since the toggle last moved
  logic [1:0] next_quiet;   // Next quiet count
  word_t word_q;            // Captured copy of the shift register
  word_t next_word_q;       // Next captured copy
  logic word_valid;         // A word has been captured since reset
  logic next_word_valid;    // Next valid flag
  logic word_quiet;         // Shift register is settled

  // The bus is sampled only once the toggle has been still for a few
  // cycles, so its bits are settled. A shift landing inside the sample
  // window is a host timing fault, as it would be on the pin itself.
  // Only the synchronised toggle is read; the raw one may be metastable.
  // Limitation: a whole word flips the toggle an even number of times,
  // so capture leans on the toggle being caught moving mid-frame, or
  // else on the copy taken every quiet cycle, which lands after the frame.
  always_comb begin
    word_quiet = (synced[SYNC_TOGGLE] == toggle_seen) && (quiet_cnt == QUIET_CYCLES);
    next_toggle_seen = synced[SYNC_TOGGLE];
    next_word_q = word_q;
    next_word_valid = word_valid;
    if (synced[SYNC_TOGGLE] != toggle_seen) begin
      // Fresh shift seen, start counting again
      next_quiet = 2'h0;
    end else if (quiet_cnt != QUIET_CYCLES) begin
      // Still settling
      next_quiet = quiet_cnt + 2'h1;
    end else begin
      // Saturated
      next_quiet = quiet_cnt;
    end
    // whole word captured with its layout
    if (word_quiet) begin
      next_word_q = link.word;
      next_word_valid = 1'b1;
    end
  end

  // Registers only; frozen while the clock enable is low
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      toggle_seen <= 1'b0;
      quiet_cnt <= 2'h0;
      word_q <= '0;
      word_valid <= 1'b0;
    end else if (i_ce) begin
      toggle_seen <= next_toggle_seen;
      quiet_cnt <= next_quiet;
      word_q <= next_word_q;
      word_valid <= next_word_valid;
    end
  end

  // ----------------------------------------------------------------
  // Strobe edges
  // ----------------------------------------------------------------
  logic update_prev;       // Update strobe one cycle ago
  logic reset_prev;        // Code reset one cycle ago
  logic update_rise;       // Update strobe rising edge
  logic reset_rise;        // Code reset rising edge
  logic load_active;       // Load strobe low with a word to copy
  code_t reset_code;       // Code chosen by the select level

  // Load is refused on a reset edge; reset outranks every strobe
  // edge of the reset pin, no serial clock needed
  always_comb begin
    update_rise = synced[SYNC_UPDATE] && !update_prev;
    reset_rise = synced[SYNC_RESET] && !reset_prev;
    load_active = !synced[SYNC_LOAD] && word_valid && !reset_rise;
    reset_code = synced[SYNC_SELECT] ? MIDSCALE_CODE : ZERO_CODE;
  end

  // ----------------------------------------------------------------
  // Input and output registers
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0][CODE_BITS-1:0] input_code;       // Input stage
  logic [CHANNELS-1:0][CODE_BITS-1:0] output_code;      // Output stage
  logic [CHANNELS-1:0][CODE_BITS-1:0] next_input_code;  // Next input stage
  logic [CHANNELS-1:0][CODE_BITS-1:0] next_output_code; // Next output stage

  // Reset outranks load and update; update uses the inputs as they
  // stood before any load in the same cycle
  always_comb begin
    next_input_code = input_code;
    next_output_code = output_code;
    if (reset_rise) begin
      for (int k = 0; k < CHANNELS; k++) begin
        next_input_code[k] = reset_code;
        next_output_code[k] = reset_code;
      end
    end else begin
      for (int k = 0; k < CHANNELS; k++) begin
        if (load_active && chan_hit(word_q, k[1:0])) begin
          next_input_code[k] = word_q[CODE_MSB_POS:0];
        end
      end
      if (update_rise) begin
        next_output_code = input_code;
      end
    end
  end

  // Async reset gives zero codes; the select only steers the code reset pin
  // two stages per channel
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      update_prev <= 1'b0;
      reset_prev <= 1'b0;
      input_code <= {CHANNELS{ZERO_CODE}};
      output_code <= {CHANNELS{ZERO_CODE}};
    end else if (i_ce) begin
      update_prev <= synced[SYNC_UPDATE];
      reset_prev <= synced[SYNC_RESET];
      input_code <= next_input_code;
      output_code <= next_output_code;
    end
  end

  // codes presented straight from the registers
  assign o_code = output_code;
  assign o_input_code = input_code;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  // System clock by default; chain checks name the link clock themselves
  // so their samples follow the shifter, not the capture logic.

  update_copy_a: assert property (
    i_ce && update_rise && !reset_rise |=> output_code == $past(input_code))
    else $error("update edge did not copy all input registers");

  reset_mid_a: assert property (
    i_ce && reset_rise && synced[SYNC_SELECT] |=> input_code == {CHANNELS{MIDSCALE_CODE}}
      && output_code == {CHANNELS{MIDSCALE_CODE}})
    else $error("reset with select high did not give mid-scale");

  reset_zero_a: assert property (
    i_ce && reset_rise && !synced[SYNC_SELECT] |=> input_code == {CHANNELS{ZERO_CODE}}
      && output_code == {CHANNELS{ZERO_CODE}})
    else $error("reset with select low did not give zero");

  reset_pin_a: assert property (
    i_ce && $rose(synced[SYNC_RESET]) |=> output_code == input_code)
    else $error("reset pin edge did not act on both stages");

  bcast_load_a: assert property (
    i_ce && load_active && word_q[BCAST_POS] |=> input_code == {CHANNELS{$past(word_q[CODE_MSB_POS:0])}})
    else $error("broadcast load missed a channel");

  input_hold_a: assert property (
    i_ce && synced[SYNC_LOAD] && !reset_rise |=> $stable(input_code))
    else $error("input registers moved with load high");

  output_hold_a: assert property (
    !(i_ce && (update_rise || reset_rise)) |=> $stable(o_code))
    else $error("output codes moved between updates");

  // Clock enable low freezes both register stages
  ce_freeze_a: assert property (
    !i_ce |=> $stable(input_code) && $stable(output_code))
    else $error("registers moved with clock enable low");

  // A held update level acts once, not every cycle
  update_once_a: assert property (
    i_ce && update_rise |=> !update_rise)
    else $error("update edge seen twice for one pulse");

  // Captured word only moves after a quiet window
  capture_gate_a: assert property (
    i_ce && !word_quiet |=> $stable(word_q))
    else $error("word captured while the shifter was moving");

  // Chain output steps with the shifter, on the link clock
  chain_out_a: assert property (@(posedge i_sclk) disable iff (!i_arst_n)
    !i_cs_n |=> o_serial_out == $past(link.word[WORD_BITS-2]))
    else $error("serial out is not the top shifter stage");

  // Chain output holds while deselected
  chain_hold_a: assert property (@(posedge i_sclk) disable iff (!i_arst_n)
    i_cs_n |=> $stable(o_serial_out))
    else $error("serial out moved while deselected");

  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++) begin : g_chk
      addr_load_a: assert property (
        i_ce && load_active && !word_q[BCAST_POS] && {word_q[ADDR_HI_POS], word_q[ADDR_LO_POS]} == c
          |=> input_code[c] == $past(word_q[CODE_MSB_POS:0]))
        else $error("addressed channel not loaded");
      addr_skip_a: assert property (
        i_ce && load_active && !word_q[BCAST_POS] && {word_q[ADDR_HI_POS], word_q[ADDR_LO_POS]} != c
          |=> $stable(input_code[c]))
        else $error("unaddressed channel was written");
    end
  endgenerate

endmodule

`default_nettype wire

// ==== hw/serial_shifter.sv ====
// Serial shift register running on the link's own clock.
// Assumes chip select and data are driven by the host relative to this clock.
`timescale 1ns/10ps
`default_nettype none

module serial_shifter import qdac_pkg::*; (
  input wire logic i_sclk,
  input wire logic i_arst_n,
  input wire logic i_cs_n,
  input wire logic i_serial_in,
  serial_word_if.producer link
);

  // ----------------------------------------------------------------
  // Shift state
  // ----------------------------------------------------------------
  word_t shift_reg;     // First bit received ends up at the top
  word_t next_shift;    // Next shift contents
  logic flip;           // Shift event toggle
  logic next_flip;      // Next toggle

  always_comb begin
    next_shift = shift_reg;
    next_flip = flip;
    if (!i_cs_n) begin
      next_shift = {shift_reg[WORD_BITS-2:0], i_serial_in};
      next_flip = ~flip;
    end
  end

  // Registers only; the link clock may stop between frames
  always_ff @(posedge i_sclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift_reg <= '0;
      flip <= 1'b0;
    end else begin
      shift_reg <= next_shift;
      flip <= next_flip;
    end
  end

  assign link.word = shift_reg;
  assign link.toggle = flip;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  shift_in_a: assert property (@(posedge i_sclk) disable iff (!i_arst_n)
    !i_cs_n |=> shift_reg[0] == $past(i_serial_in) && shift_reg[WORD_BITS-1] == $past(shift_reg[WORD_BITS-2]))
    else $error("shift register did not advance one bit");
  select_hold_a: assert property (@(posedge i_sclk) disable iff (!i_arst_n)
    i_cs_n |=> $stable(shift_reg) && $stable(flip))
    else $error("shift register moved while deselected");

endmodule

`default_nettype wire

// ==== hw/serial_word_if.sv ====
// Carrier for the shift register word between link and system logic.
// Assumes the producer runs on the serial clock and the consumer crosses it.
`timescale 1ns/10ps
`default_nettype none

interface serial_word_if;
  import qdac_pkg::*;

  word_t word;   // Shift register contents, link domain
  logic toggle;  // Flips on every shift, link domain

  // Shifter side drives, system side only reads
  modport producer(output word, output toggle);
  modport consumer(input word, input toggle);
endinterface

`default_nettype wire

// ==== tb/host_model.sv ====
// Host side model: drives serial clock, select and data into the block.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/10ps
`default_nettype none

module host_model import qdac_pkg::*; (
  output logic o_sclk,      // Serial clock, idles high
  output logic o_cs_n,      // Chip select, active low
  output logic o_serial_in  // Serial data into the block
);
  // Half period of the 6 ns link clock
  localparam realtime HALF = 3.0;

  // Idle levels at time zero
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_serial_in = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame transfer
  // ----------------------------------------------------------------
  // MSB first, select falls with clock high
  task automatic send_word(input word_t w, input int stretch);
    #1.7;
    o_cs_n = 1'b0;
    for (int i = WORD_BITS - 1; i >= 0; i--) begin
      // Stretch slows the high phase only
      #(HALF * stretch) o_sclk = 1'b0;
      // Data moves on the falling edge, clear of the sampling edge
      o_serial_in = w[i];
      #HALF o_sclk = 1'b1;
    end
    #HALF o_cs_n = 1'b1;
    // Released data shows the inverse, never a stale bit
    o_serial_in = ~o_serial_in;
  endtask

  // Clock edges while deselected; these must shift nothing
  task automatic stray_clocks(input int n);
    repeat (n) begin
      #HALF o_sclk = 1'b0;
      o_serial_in = ~o_serial_in;
      #HALF o_sclk = 1'b1;
    end
  endtask
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the quad converter serial load logic.
// Assumes the host model drives the link and the bench drives the strobes.
`timescale 1ns/10ps
`default_nettype none

module tb_top import qdac_pkg::*; ;
  // ----------------------------------------------------------------
  // Signals and expectations
  // ----------------------------------------------------------------
  localparam int TIMEOUT_CYCLES = 6000;  // Far above the expected run
  logic clk, arst_n, sclk, cs_n, sdin, sout;  // Clocks and link
  logic load_n, upd, crst, rsel, ce;  // Strobes, select and clock enable
  logic [CHANNELS-1:0][CODE_BITS-1:0] in_code, out_code;  // Observed codes
  code_t exp_in [CHANNELS];  // Expected input registers
  code_t exp_out [CHANNELS];  // Expected output registers
  int fails, samples_checked, cycles;
  integer seed;
  word_t w;

  host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_serial_in(sdin));

  // Clock enable driven by the bench; one scenario freezes the block
  quad_dac_serial_load_logic uut (
    .i_clk(clk), .i_arst_n(arst_n), .i_ce(ce), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_serial_in(sdin), .i_load_n(load_n),
    .i_output_update_strobe(upd), .i_code_reset(crst),
    .i_reset_level_select(rsel), .o_serial_out(sout),
    .o_input_code(in_code), .o_code(out_code)
  );

  // System clock, 50 ns period
  always #25 clk = ~clk;

  // Hang guard counts as a mismatch
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == TIMEOUT_CYCLES) begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Expectation functions
  // ----------------------------------------------------------------
  function automatic void expect_load(input word_t wd);
    for (int ch = 0; ch < CHANNELS; ch++) begin
      // Broadcast reaches all, else only the addressed one
      if (wd[BCAST_POS] || ch == {wd[ADDR_HI_POS], wd[ADDR_LO_POS]}) begin
        exp_in[ch] = wd[CODE_MSB_POS:0];
      end
    end
  endfunction

  function automatic void expect_update();
    for (int ch = 0; ch < CHANNELS; ch++) begin
      exp_out[ch] = exp_in[ch];
    end
  endfunction

  function automatic void expect_reset(input logic sel);
    for (int ch = 0; ch < CHANNELS; ch++) begin
      exp_in[ch] = sel ? MIDSCALE_CODE : ZERO_CODE;
      exp_out[ch] = sel ? MIDSCALE_CODE : ZERO_CODE;
    end
  endfunction

  // ----------------------------------------------------------------
  // Driver and compare tasks
  // ----------------------------------------------------------------
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_all();
    for (int ch = 0; ch < CHANNELS; ch++) begin
      check(in_code[ch], exp_in[ch]);
      check(out_code[ch], exp_out[ch]);
    end
  endtask

  // Strobes held 3 cycles so the synchroniser cannot miss them
  task automatic do_load();
    load_n = 1'b0;
    wait_n(3);
    load_n = 1'b1;
    wait_n(4);
  endtask

  task automatic do_update();
    upd = 1'b1;
    wait_n(3);
    upd = 1'b0;
    wait_n(4);
  endtask

  // Select kept stable well around the reset edge
  task automatic do_reset(input logic sel);
    rsel = sel;
    wait_n(4);
    crst = 1'b1;
    wait_n(3);
    crst = 1'b0;
    wait_n(5);
    expect_reset(sel);
    check_all();
  endtask

  task automatic report_and_stop();
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    ce = 1'b1;
    load_n = 1'b1;
    upd = 1'b0;
    crst = 1'b0;
    rsel = 1'b0;
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    seed = 32'h9701;
    expect_reset(1'b0);
    wait_n(16);
    arst_n = 1'b1;
    wait_n(2);
    check_all();
    // First two words are corners: broadcast of all ones, channel 3 zero
    for (int i = 0; i < 24; i++) begin
      w = (i == 0) ? 24'hE0FFFF : (i == 1) ? 24'hC00000 : word_t'($random(seed));
      host.send_word(w, (i % 3 == 0) ? 3 : 1);
      check({15'h0, sout}, {15'h0, w[ADDR_HI_POS]});
      host.stray_clocks(4);
      check({15'h0, sout}, {15'h0, w[ADDR_HI_POS]});
      wait_n(8);
      do_load();
      expect_load(w);
      check_all();
      if (i % 2 == 1) begin
        do_update();
        expect_update();
        check_all();
      end
      if (i == 12) begin
        do_reset(1'b1);
      end
    end
    // Load held low while shifting: registers follow the shifter
    load_n = 1'b0;
    wait_n(2);
    // Broadcast, so the words that flow through on the way are all overwritten
    w = word_t'($random(seed));
    w[BCAST_POS] = 1'b1;
    host.send_word(w, 1);
    wait_n(10);
    load_n = 1'b1;
    wait_n(4);
    expect_load(w);
    check_all();
    // Clock enable low across a whole update pulse: nothing may move
    ce = 1'b0;
    do_update();
    ce = 1'b1;
    wait_n(4);
    check_all();
    do_reset(1'b0);
    report_and_stop();
  end
endmodule

`default_nettype wire
